// ---- conv_model.sv ----
// converter model: supplies device clock edge instants
// assumes the bench clock; one edge every second cycle
module conv_model (
   input wire clk,
   input wire rst_n,
   output reg dev_clk_en
);
   timeunit 1ns;
   timeprecision 1ns;
   initial dev_clk_en = 1'b0;
   // ========
   // edge instants that releases line up with
   always @(posedge clk)
      dev_clk_en <= #1 rst_n & ~dev_clk_en;
endmodule

// ---- delay_line.v ----
// global sysref delay: shifts a pulse by a code of 339 ps steps
// converted to whole clk cycles (rounded down); assumes one clk domain
`include "sysref_map.vh"
module delay_line (
   input wire clk,
   input wire rst_n,
   input wire [7:0] code,
   input wire din,
   output reg dout
);
   reg [255:0] tap_r;
   wire [17:0] delay_ps;
   wire [17:0] cyc_full;
   wire [7:0] cyc;
   assign delay_ps = code * 18'd339;
   assign cyc_full = delay_ps / 18'd50000;
   assign cyc = cyc_full[7:0];
   always @(posedge clk) begin
      if (!rst_n) begin
         tap_r <= 256'h0;
         dout <= 1'b0;
      end else begin
         tap_r <= {tap_r[254:0], din};
         if (cyc == 8'h00) begin
            dout <= din;
         end else begin
            dout <= tap_r[cyc - 8'h01];
         end
      end
   end
endmodule

// ---- ratio_divider.v ----
// one divider stage: counts ratio-1 down to 0, pulses tick at wrap
// assumes en is a one-cycle enable on clk; ratio >= 2
module ratio_divider (
   input wire clk,
   input wire rst_n,
   input wire clr,
   input wire en,
   input wire [4:0] ratio,
   output wire tick
);
   reg [4:0] cnt_r;
   assign tick = en && (cnt_r == 5'h00);
   always @(posedge clk) begin
      if (!rst_n || clr) begin
         cnt_r <= 5'h00;
      end else if (en) begin
         if (cnt_r == 5'h00) begin
            cnt_r <= ratio - 5'h01;
         end else begin
            cnt_r <= cnt_r - 5'h01;
         end
      end
   end
endmodule

// ---- sysref_chk.sv ----
// checker: port properties of the sysref pulse generator
// assumes one clock and sync active-low reset; bound below
module sysref_chk (
   input wire clk,
   input wire rst_n,
   input wire dev_clk_en,
   input wire wr_en,
   input wire [2:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [2:0] rd_addr,
   input wire power_down,
   input wire external_trigger_pin,
   input wire [7:0] rd_data,
   input wire pulse_output,
   input wire sysref_powered,
   input wire busy
);
   // ========
   // helpers
   reg mode_r;
   wire ctrl_wr = wr_en && wr_addr == 3'h3;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   always @(posedge clk) begin
      if (!rst_n)
         mode_r <= 1'b0;
      else if (ctrl_wr)
         mode_r <= wr_data[1];
   end
   sequence s_trig;
      ctrl_wr && wr_data[2] && !power_down;
   endsequence
   sequence s_stop;
      busy && mode_r && ctrl_wr && wr_data[2:1] == 2'b00;
   endsequence
   sequence s_idle;
      !busy [*5];
   endsequence
   // ========
   // properties
   a_reset_outs: assert property (disable iff (1'b0)
      !rst_n |=> !busy && !pulse_output && !sysref_powered)
      else $error("outputs set after reset");
   a_trig_busy: assert property (s_trig |=> busy && sysref_powered)
      else $error("trigger did not start");
   a_pd_power: assert property (power_down |=> !sysref_powered)
      else $error("powered while down");
   a_pd_refuse: assert property (power_down && !busy |=> !busy)
      else $error("start while down");
   a_idle_quiet: assert property (s_idle |-> !$rose(pulse_output))
      else $error("pulse while idle");
   a_pulse_width: assert property (
      $rose(pulse_output) |-> pulse_output [*2])
      else $error("pulse too short");
   a_rd_unmapped: assert property (rd_addr > 3'h3 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_mode_stop: assert property (s_stop |-> ##[1:2] !busy)
      else $error("run not stopped");
endmodule
bind sysref_pulse_generator sysref_chk chk_u (.clk(clk), .rst_n(rst_n),
   .dev_clk_en(dev_clk_en), .wr_en(wr_en), .wr_addr(wr_addr),
   .wr_data(wr_data), .rd_addr(rd_addr), .power_down(power_down),
   .external_trigger_pin(external_trigger_pin), .rd_data(rd_data),
   .pulse_output(pulse_output), .sysref_powered(sysref_powered),
   .busy(busy));

// ---- sysref_map.vh ----
// constants for the sysref pulse generator: field layout, reset values,
// timing counts. included by the design files by bare name.
`ifndef SYSREF_MAP_VH
`define SYSREF_MAP_VH
// ==========================================================
// register write addresses (no bus: strobe-select codes)
`define SR_ADDR_ALIGN 3'h0
`define SR_ADDR_COUNT 3'h1
`define SR_ADDR_DELAY 3'h2
`define SR_ADDR_CTRL 3'h3
// ==========================================================
// control word bit positions
`define SR_CTRL_SRC 0
`define SR_CTRL_MODE 1
`define SR_CTRL_TRIG 2
// ==========================================================
// reset values
`define SR_ALIGN_RST 7'h01
`define SR_COUNT_RST 8'h02
`define SR_DELAY_RST 8'h00
// ==========================================================
// alignment field layout
`define SR_CASCADE_BIT 6
// ==========================================================
// timing: delay step in ps, clock period in ps
`define SR_STEP_PS 339
`define SR_CLK_PS 50000
// pulse high and low half-width in release periods
`define SR_PULSE_HALF 8'h01
`endif

// ---- sysref_pulse_generator.v ----
// sysref pulse generator: alignment divider, pulse counter, trigger, delay
// assumes register writes arrive as one-cycle strobes on clk and that
// device_clock_output phase is represented by the dev_clk_en enable pulse
//
// Functional notes
// [RL1] pulses release only on alignment divider wrap, coincident clock edges
// [RL2] software sets alignment divider to lcm of active channel dividers
// [RL3] cascade bit 6 set: product of upper and lower; clear: lower only
// [RL4] lower stage divides by code plus two, 2 to 9
// [RL5] upper stage ratios 2,4,6,8,4,8,12,16 cascaded before lower stage
// [RL6] software prefers cascaded setting with higher ratio where recommended
// [RL7] counted mode emits pulse_count pulses, 1 to 255, reset value 2
// [RL8] software sets source and mode to 0 for counted pulses
// [RL9] global delay equals code times 339 ps on all sysref outputs; code rounds it down to whole clk cycles
// [RL10] source 0 uses trigger bit; source 1 uses external pin
// [RL11] mode 0 counted burst; mode 1 continuous pulses
// [RL12] trigger write powers up sysref and releases pulses
// [RL13] trigger write also realigns phase and applies delay
// [RL14] trigger bit self-clears in counted mode
// [RL15] internal source: each trigger write starts fresh generation
// [RL16] external source: trigger arms, next pin rising edge starts
// [RL17] continuous runs until mode cleared or powered down; trigger reads undefined
`include "sysref_map.vh"
module sysref_pulse_generator (
   input wire clk,
   input wire rst_n,
   input wire dev_clk_en,
   input wire wr_en,
   input wire [2:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [2:0] rd_addr,
   input wire power_down,
   input wire external_trigger_pin,
   output reg [7:0] rd_data,
   output reg pulse_output,
   output reg sysref_powered,
   output reg busy
);
// ==========================================================
// state codes
   localparam ST_IDLE = 2'h0;
   localparam ST_ARMED = 2'h1;
   localparam ST_RUN = 2'h2;
// ==========================================================
// registers
   reg [6:0] release_align_divider_r;
   reg [7:0] pulse_count_r;
   reg [7:0] global_pulse_delay_r;
   reg pulse_source_select_r;
   reg pulse_mode_select_r;
   reg pulse_trigger_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [7:0] left_r;
   reg [7:0] left_nxt;
   reg level_r;
   reg level_nxt;
   reg [7:0] half_r;
   reg [7:0] half_nxt;
   reg realign_r;
   reg ext_s1_r;
   reg ext_s2_r;
   reg ext_d_r;
   reg [4:0] upper_ratio;
   wire [4:0] lower_ratio;
   wire upper_tick;
   wire lower_tick;
   wire lower_en;
   wire release_tick;
   wire ext_rise;
   wire trig_wr;
   wire cascade;
   wire pulse_raw;
   wire pulse_dly;
// ==========================================================
// register writes
   assign trig_wr = wr_en && (wr_addr == `SR_ADDR_CTRL) &&
      wr_data[`SR_CTRL_TRIG];
   always @(posedge clk) begin
      if (!rst_n) begin
         release_align_divider_r <= `SR_ALIGN_RST;
         pulse_count_r <= `SR_COUNT_RST;
         global_pulse_delay_r <= `SR_DELAY_RST;
         pulse_source_select_r <= 1'b0;
         pulse_mode_select_r <= 1'b0;
      end else if (wr_en) begin
         case (wr_addr)
            `SR_ADDR_ALIGN: release_align_divider_r <= wr_data[6:0];
            `SR_ADDR_COUNT: pulse_count_r <= wr_data;
            `SR_ADDR_DELAY: global_pulse_delay_r <= wr_data;
            `SR_ADDR_CTRL: begin
               pulse_source_select_r <= wr_data[`SR_CTRL_SRC];
               pulse_mode_select_r <= wr_data[`SR_CTRL_MODE];
            end
            default: begin
            end
         endcase
      end
   end
// ==========================================================
// trigger bit: held in continuous mode, self-clears in counted mode
   always @(posedge clk) begin
      if (!rst_n) begin
         pulse_trigger_r <= 1'b0;
      end else if (trig_wr) begin
         pulse_trigger_r <= wr_data[`SR_CTRL_MODE]; // [RL14]
      end else if (!pulse_mode_select_r) begin
         pulse_trigger_r <= 1'b0; // [RL14]
      end
   end
// ==========================================================
// read-back; trigger bit reads as its internal copy (undefined by spec)
   always @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else begin
         case (rd_addr)
            `SR_ADDR_ALIGN: rd_data <= {1'b0, release_align_divider_r};
            `SR_ADDR_COUNT: rd_data <= pulse_count_r;
            `SR_ADDR_DELAY: rd_data <= global_pulse_delay_r;
            `SR_ADDR_CTRL: rd_data <= {3'h0, busy, sysref_powered,
               pulse_trigger_r, pulse_mode_select_r,
               pulse_source_select_r}; // [RL17]
            default: rd_data <= 8'h00;
         endcase
      end
   end
// ==========================================================
// external trigger synchroniser and edge detect
   always @(posedge clk) begin
      if (!rst_n) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         ext_s1_r <= external_trigger_pin;
         ext_s2_r <= ext_s1_r;
         ext_d_r <= ext_s2_r;
      end
   end
   assign ext_rise = ext_s2_r && !ext_d_r;
// ==========================================================
// release-alignment divider
   assign cascade = release_align_divider_r[`SR_CASCADE_BIT]; // [RL3]
   assign lower_ratio = {2'h0, release_align_divider_r[2:0]} + 5'h02; // [RL4]
   always @* begin
      case (release_align_divider_r[5:3]) // [RL5]
         3'h0: upper_ratio = 5'h02;
         3'h1: upper_ratio = 5'h04;
         3'h2: upper_ratio = 5'h06;
         3'h3: upper_ratio = 5'h08;
         3'h4: upper_ratio = 5'h04;
         3'h5: upper_ratio = 5'h08;
         3'h6: upper_ratio = 5'h0C;
         3'h7: upper_ratio = 5'h10;
         default: upper_ratio = 5'h02;
      endcase
   end
   ratio_divider u_upper (
      .clk(clk),
      .rst_n(rst_n),
      .clr(realign_r),
      .en(dev_clk_en),
      .ratio(upper_ratio),
      .tick(upper_tick)
   );
   assign lower_en = cascade ? upper_tick : dev_clk_en; // [RL3] [RL5]
   ratio_divider u_lower (
      .clk(clk),
      .rst_n(rst_n),
      .clr(realign_r),
      .en(lower_en),
      .ratio(lower_ratio),
      .tick(lower_tick)
   );
   // stale ticks are held off until the dividers have been realigned
   assign release_tick = lower_tick && !realign_r; // [RL1] [RL13]
// ==========================================================
// power and realign on trigger write
   always @(posedge clk) begin
      if (!rst_n) begin
         sysref_powered <= 1'b0;
         realign_r <= 1'b0;
      end else begin
         realign_r <= trig_wr; // [RL13]
         if (power_down) begin
            sysref_powered <= 1'b0; // [RL17]
         end else if (trig_wr) begin
            sysref_powered <= 1'b1; // [RL12]
         end
      end
   end
// ==========================================================
// pulse sequencer
   always @* begin
      state_nxt = state_r;
      left_nxt = left_r;
      level_nxt = level_r;
      half_nxt = half_r;
      case (state_r)
         ST_IDLE: begin
            level_nxt = 1'b0;
            if (trig_wr && !power_down) begin
               // continuous run keeps no count, so clearing mode ends it
               left_nxt = wr_data[`SR_CTRL_MODE] ? 8'h00 : pulse_count_r; // [RL7]
               half_nxt = 8'h00;
               if (wr_data[`SR_CTRL_SRC]) begin
                  state_nxt = ST_ARMED; // [RL16]
               end else begin
                  state_nxt = ST_RUN; // [RL10] [RL15]
               end
            end
         end
         ST_ARMED: begin
            if (ext_rise) begin
               state_nxt = ST_RUN; // [RL16]
            end
         end
         ST_RUN: begin
            if (release_tick) begin
               if (half_r != 8'h00) begin
                  half_nxt = half_r - 8'h01;
               end else if (level_r) begin
                  level_nxt = 1'b0;
                  half_nxt = `SR_PULSE_HALF - 8'h01;
                  if (!pulse_mode_select_r) begin
                     left_nxt = left_r - 8'h01; // [RL7] [RL11]
                     if (left_r == 8'h01) begin
                        state_nxt = ST_IDLE;
                     end
                  end
               end else begin
                  level_nxt = 1'b1; // [RL1]
                  half_nxt = `SR_PULSE_HALF - 8'h01;
               end
            end
            if (pulse_mode_select_r == 1'b0 && left_r == 8'h00) begin
               state_nxt = ST_IDLE; // [RL17]
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (trig_wr && !power_down && state_r != ST_IDLE) begin
         left_nxt = wr_data[`SR_CTRL_MODE] ? 8'h00 : pulse_count_r; // [RL15]
         half_nxt = 8'h00;
         level_nxt = 1'b0;
         state_nxt = wr_data[`SR_CTRL_SRC] ? ST_ARMED : ST_RUN; // [RL10]
      end
      if (power_down) begin
         state_nxt = ST_IDLE; // [RL17]
         level_nxt = 1'b0;
      end
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         left_r <= 8'h00;
         level_r <= 1'b0;
         half_r <= 8'h00;
         busy <= 1'b0;
      end else begin
         state_r <= state_nxt;
         left_r <= left_nxt;
         level_r <= level_nxt;
         half_r <= half_nxt;
         busy <= (state_nxt != ST_IDLE);
      end
   end
// ==========================================================
// global delay and output
   assign pulse_raw = level_r && sysref_powered;
   delay_line u_delay (
      .clk(clk),
      .rst_n(rst_n),
      .code(global_pulse_delay_r),
      .din(pulse_raw),
      .dout(pulse_dly)
   ); // [RL9] [RL13]
   always @(posedge clk) begin
      if (!rst_n) begin
         pulse_output <= 1'b0;
      end else begin
         pulse_output <= pulse_dly;
      end
   end
endmodule

// ---- sysref_pulse_generator_tb.sv ----
// bench: register tasks and pulse counting for the generator
// assumes the converter model and the checker bind
`include "sysref_map.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
   mismatches++; $display("Error %s exp %0h got %0h", n, e, s); end end
module sysref_pulse_generator_tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg wr_en = 1'b0;
   reg [2:0] wr_addr = 3'h0;
   reg [7:0] wr_data = 8'h00;
   reg [2:0] rd_addr = 3'h0;
   reg power_down = 1'b0;
   reg ext_pin = 1'b0;
   wire dev_clk_en, pulse_output, sysref_powered, busy;
   wire [7:0] rd_data;
   integer mismatches = 0;
   integer tests_run = 0;
   integer cyc = 0;
   integer n_rise, t1, t2, base, i;
   reg [7:0] v;
   reg [7:0] codes [0:5] = '{8'h00, 8'h07, 8'h0E, 8'h4E, 8'h60, 8'h7F};
   integer ratio [0:5] = '{2, 9, 8, 32, 8, 144};
   integer cnt [0:5] = '{255, 2, 3, 2, 3, 2};
   sysref_pulse_generator dut_u (.clk(clk), .rst_n(rst_n),
      .dev_clk_en(dev_clk_en), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .power_down(power_down),
      .external_trigger_pin(ext_pin), .rd_data(rd_data),
      .pulse_output(pulse_output), .sysref_powered(sysref_powered),
      .busy(busy));
   conv_model model_u (.clk(clk), .rst_n(rst_n), .dev_clk_en(dev_clk_en));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         final_report;
      end
   end
   // ========
   // tasks
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task wr(input [2:0] a, input [7:0] d);
      @(posedge clk);
      #1 wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(posedge clk);
      #1 wr_en = 1'b0;
   endtask
   task rd(input [2:0] a);
      @(posedge clk);
      #1 rd_addr = a;
      @(posedge clk);
      #1 v = rd_data;
   endtask
   // phased control write (none for 0), then count rising pulses
   task run(input [7:0] c, input integer win);
      reg last;
      integer k;
      n_rise = 0;
      t1 = 0;
      t2 = 0;
      last = pulse_output;
      if (c != 8'h00) begin
         @(posedge clk);
         while (dev_clk_en !== 1'b1) @(posedge clk);
         wr(3'h3, c);
      end
      for (k = 0; k < win; k++) begin
         @(posedge clk);
         #2;
         if (pulse_output === 1'b1 && last !== 1'b1) begin
            n_rise++;
            if (n_rise == 1) t1 = k;
            if (n_rise == 2) t2 = k;
         end
         last = pulse_output;
      end
   endtask
   // ========
   // tests
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(3'h0);
      `CHK("align", 8'h01, v)
      rd(3'h1);
      `CHK("count", 8'h02, v)
      rd(3'h2);
      `CHK("delay", 8'h00, v)
      rd(3'h3);
      `CHK("src mode", 2'b00, v[1:0])
      rd(3'h5);
      `CHK("unmapped", 8'h00, v)
      for (i = 0; i < 6; i++) begin
         wr(3'h0, codes[i]);
         wr(3'h1, cnt[i][7:0]);
         run(8'h04, 4 * ratio[i] * (cnt[i] + 1) + 40);
         `CHK("rises", cnt[i], n_rise)
         `CHK("period", 4 * ratio[i], t2 - t1)
         `CHK("done", 1'b0, busy)
      end
      `CHK("powered", 1'b1, sysref_powered)
      wr(3'h0, 8'h07);
      wr(3'h1, 8'h02);
      wr(3'h3, 8'h04);
      repeat (8) @(posedge clk);
      run(8'h04, 148);
      `CHK("restart", 2, n_rise)
      wr(3'h1, 8'h01);
      run(8'h04, 100);
      base = t1;
      `CHK("single", 1, n_rise)
      wr(3'h2, 8'hFF);
      rd(3'h2);
      `CHK("delay rd", 8'hFF, v)
      run(8'h04, 100);
      `CHK("delayed", base + 255 * `SR_STEP_PS / `SR_CLK_PS, t1)
      wr(3'h0, 8'h00);
      run(8'h06, 200);
      `CHK("running", 1'b1, busy)
      `CHK("many", 1'b1, n_rise > 20)
      wr(3'h3, 8'h00);
      repeat (3) @(posedge clk);
      `CHK("stopped", 1'b0, busy)
      run(8'h05, 100);
      `CHK("armed", 1'b1, busy)
      `CHK("no pin", 0, n_rise)
      @(posedge clk);
      #1 ext_pin = 1'b1;
      run(8'h00, 100);
      `CHK("pin start", 1, n_rise)
      `CHK("pin done", 1'b0, busy)
      @(posedge clk);
      #1 ext_pin = 1'b0;
      repeat (3) @(posedge clk);
      #1 ext_pin = 1'b1;
      run(8'h00, 100);
      `CHK("unarmed", 0, n_rise)
      @(posedge clk);
      #1 power_down = 1'b1;
      run(8'h04, 60);
      `CHK("pd rises", 0, n_rise)
      `CHK("pd power", 1'b0, sysref_powered)
      `CHK("pd busy", 1'b0, busy)
      final_report;
   end
endmodule
